// ---- src/flash_host_pkg.sv ----
// Constants, types and command table for the parallel flash host controller.
package flash_host_pkg;
  localparam int CLK_NS = 8;
  // Bus timing of the flash, in ns (suspend in us), and derived cycle counts (rounded up).
  localparam int WE_LOW_NS = 40;
  localparam int WE_HIGH_NS = 30;
  localparam int READ_CYCLE_NS = 70;
  localparam int GAP_NS = 16;
  localparam int RESET_PULSE_NS = 500;
  localparam int RESET_RECOVERY_NS = 50;
  localparam int SUSPEND_US = 10;
  localparam logic [11:0] WE_LOW_CYC = 12'((WE_LOW_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [11:0] WE_HIGH_CYC = 12'((WE_HIGH_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [11:0] READ_CYC = 12'((READ_CYCLE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [11:0] GAP_CYC = 12'((GAP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [11:0] RST_LOW_CYC = 12'((RESET_PULSE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [11:0] RECOV_CYC =
    12'((RESET_RECOVERY_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [11:0] SUSPEND_CYC =
    12'((SUSPEND_US * 1000 + CLK_NS - 1) / CLK_NS);
  // Register map, byte addresses.
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_RDATA = 8'h10;
  localparam logic [7:0] REG_CFG = 8'h14;
  localparam int GO_BIT = 31;
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_REFUSED = 2;
  localparam int ST_REISSUE = 3;
  localparam int ST_SUSPENDED = 4;
  localparam int CFG_WP = 0;
  localparam int CFG_BOTTOM = 1;
  localparam logic CFG_WP_RESET = 1'b1;
  // Flash command addresses and codes.
  localparam logic [20:0] A_UNLOCK1 = 21'h000555;
  localparam logic [20:0] A_UNLOCK2 = 21'h0002aa;
  localparam logic [20:0] A_QUERY_SHORT = 21'h000055;
  localparam logic [15:0] D_UNLOCK1 = 16'h00aa;
  localparam logic [15:0] D_UNLOCK2 = 16'h0055;
  localparam logic [15:0] D_PROG = 16'h00a0;
  localparam logic [15:0] D_ERASE = 16'h0080;
  localparam logic [15:0] D_SECTOR = 16'h0050;
  localparam logic [15:0] D_BLOCK = 16'h0030;
  localparam logic [15:0] D_CHIP = 16'h0010;
  localparam logic [15:0] D_SUSPEND = 16'h00b0;
  localparam logic [15:0] D_RESUME = 16'h0030;
  localparam logic [15:0] D_ID = 16'h0090;
  localparam logic [15:0] D_QUERY = 16'h0098;
  localparam logic [15:0] D_SECID = 16'h0088;
  localparam logic [15:0] D_SECID_PROG = 16'h00a5;
  localparam logic [15:0] D_SECID_LOCK = 16'h0085;
  localparam logic [15:0] D_LOCK_WORD = 16'h0000;
  localparam logic [15:0] D_EXIT = 16'h00f0;
  localparam logic [5:0] BOOT_BOTTOM_TAG = 6'h00;
  localparam logic [5:0] BOOT_TOP_TAG = 6'h3f;
  localparam int TOGGLE_BIT = 6;

  typedef enum logic [3:0] {
    OP_READ = 4'h0, OP_PROG = 4'h1, OP_SECT_ERASE = 4'h2,
    OP_BLOCK_ERASE = 4'h3, OP_CHIP_ERASE = 4'h4, OP_SUSPEND = 4'h5,
    OP_RESUME = 4'h6, OP_ID_ENTRY = 4'h7, OP_QUERY_ENTRY = 4'h8,
    OP_QUERY_SHORT = 4'h9, OP_SECID_ENTRY = 4'ha, OP_SECID_PROG = 4'hb,
    OP_SECID_LOCK = 4'hc, OP_EXIT = 4'hd, OP_HW_RESET = 4'he
  } op_t;

  typedef struct packed {
    logic [20:0] addr;
    logic [15:0] data;
    logic last;
  } seq_word_t;

  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic rst_n;
    logic wp_n;
    logic dq_oe_n;
    logic [20:0] addr;
    logic [15:0] dq_out;
  } flash_pins_t;
endpackage

// ---- src/flash_host.sv ----
// APB-controlled host sequencer for an asynchronous parallel NOR flash.
`timescale 1ns/1ps
// Operation
// [R01] Program and erase end when two successive toggle bit reads agree.
// [R02] Erase status polling starts only after the sixth write strobe rises.
// [R03] Suspended sector reads give toggle bit fixed at one.
// [R04] Program during suspend toggles the toggle bit while running.
// [R05] Suspend toggle bit toggles in erase and suspended reads, not program.
// [R06] Suspend toggle bit valid only after the last write strobe rises.
// [R07] Polling bit: complement in program, zero in erase, one if suspended.
// [R08] Host holds a valid address during every status read.
// [R09] Write strobe pulses shorter than 5 ns are ignored by the flash.
// [R10] Writes blocked while output gate low or strobes high.
// [R11] Protect pin low guards the 32 KWord boot block from change.
// [R12] Reset pin low for the minimum pulse aborts and returns to read.
// [R13] Host waits the recovery time after reset and reissues lost work; the code only sets the reissue status bit if reset lands during suspend.
// [R14] Program needs the three-cycle unlock, erase the six-cycle sequence.
// [R15] Invalid command in an unlock sequence returns flash to read mode.
// [R16] Upper data byte is ignored in unlock cycles but driven valid.
// [R17] Query entry: unlock plus 98H at 555H, or 98H at 55H alone.
// [R18] Identification mode reads word 0000H as maker, 0001H as device.
// [R19] Exit command restores read mode, ignored while an operation runs.
// [R20] Secure serial area: 136 words, user part lockable, never erasable.
// [R21] Secure serial area program completion uses the toggle bits only.
// [R22] Secure serial area entry is unlock plus 88H at 555H.
// [R23] B0H at any address suspends erase within 10 us; 30H resumes.
// [R24] Commands written during an internal program are ignored.
// [R25] Query, identification and serial modes read info until exit or reset.
module flash_host (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output flash_host_pkg::flash_pins_t flash,
  input wire logic [15:0] flash_dq_in
);
  typedef enum logic [2:0] {
    S_IDLE = 3'h0, S_WR_LOW = 3'h1, S_WR_HIGH = 3'h2, S_RD_LOW = 3'h3,
    S_RD_GAP = 3'h4, S_RST_LOW = 3'h5, S_WAIT = 3'h6
  } state_t;

  function automatic flash_host_pkg::seq_word_t seq_word(
      flash_host_pkg::op_t op, logic [2:0] step, logic [20:0] target,
      logic [15:0] wdata);
    flash_host_pkg::seq_word_t w;
    logic [15:0] cmd;
    w = '{addr: flash_host_pkg::A_UNLOCK1, data: flash_host_pkg::D_UNLOCK1,
          last: 1'b0};
    case (op)
      flash_host_pkg::OP_PROG: cmd = flash_host_pkg::D_PROG;
      flash_host_pkg::OP_ID_ENTRY: cmd = flash_host_pkg::D_ID;
      flash_host_pkg::OP_QUERY_ENTRY: cmd = flash_host_pkg::D_QUERY;
      flash_host_pkg::OP_SECID_ENTRY: cmd = flash_host_pkg::D_SECID;
      flash_host_pkg::OP_SECID_PROG: cmd = flash_host_pkg::D_SECID_PROG;
      flash_host_pkg::OP_SECID_LOCK: cmd = flash_host_pkg::D_SECID_LOCK;
      default: cmd = flash_host_pkg::D_ERASE;
    endcase
    case (op)
      flash_host_pkg::OP_SUSPEND: w = '{target, flash_host_pkg::D_SUSPEND, 1'b1};
      flash_host_pkg::OP_RESUME: w = '{target, flash_host_pkg::D_RESUME, 1'b1};
      flash_host_pkg::OP_EXIT: w = '{target, flash_host_pkg::D_EXIT, 1'b1};
      flash_host_pkg::OP_QUERY_SHORT: begin // see [R17]
        w = '{flash_host_pkg::A_QUERY_SHORT, flash_host_pkg::D_QUERY, 1'b1};
      end
      default: begin
        // Upper byte of every command word is driven low.  // see [R16]
        if (step == 3'h1 || step == 3'h4) begin
          w = '{flash_host_pkg::A_UNLOCK2, flash_host_pkg::D_UNLOCK2, 1'b0};
        end else if (step == 3'h2) begin
          w = '{flash_host_pkg::A_UNLOCK1, cmd, 1'b0};
          w.last = (op == flash_host_pkg::OP_ID_ENTRY) ||
                   (op == flash_host_pkg::OP_QUERY_ENTRY) ||
                   (op == flash_host_pkg::OP_SECID_ENTRY); // see [R17] [R22]
        end else if (step == 3'h3) begin
          if (op == flash_host_pkg::OP_PROG ||
              op == flash_host_pkg::OP_SECID_PROG) begin
            w = '{target, wdata, 1'b1};
          end else if (op == flash_host_pkg::OP_SECID_LOCK) begin
            w = '{target, flash_host_pkg::D_LOCK_WORD, 1'b1};
          end
        end else if (step == 3'h5) begin
          if (op == flash_host_pkg::OP_SECT_ERASE) begin
            w = '{target, flash_host_pkg::D_SECTOR, 1'b1};
          end else if (op == flash_host_pkg::OP_BLOCK_ERASE) begin
            w = '{target, flash_host_pkg::D_BLOCK, 1'b1};
          end else begin
            w = '{flash_host_pkg::A_UNLOCK1, flash_host_pkg::D_CHIP, 1'b1};
          end
        end
      end
    endcase
    return w;
  endfunction

  function automatic logic alters_array(flash_host_pkg::op_t op);
    return op == flash_host_pkg::OP_PROG || op == flash_host_pkg::OP_SECT_ERASE
        || op == flash_host_pkg::OP_BLOCK_ERASE
        || op == flash_host_pkg::OP_CHIP_ERASE;
  endfunction

  function automatic logic polls(flash_host_pkg::op_t op);
    return alters_array(op) || op == flash_host_pkg::OP_RESUME ||
           op == flash_host_pkg::OP_SECID_PROG ||
           op == flash_host_pkg::OP_SECID_LOCK;
  endfunction

  state_t state, next_state;
  flash_host_pkg::op_t op, next_op, go_op;
  logic [20:0] addr, next_addr;
  logic [15:0] wdata, next_wdata, rdata, next_rdata;
  logic [2:0] step, next_step;
  logic [11:0] timer, next_timer;
  logic busy, next_busy, done, next_done, refused, next_refused;
  logic reissue, next_reissue, suspended, next_suspended;
  logic polling, next_polling, prev_valid, next_prev_valid;
  logic prev_bit, next_prev_bit, cfg_wp_n, next_cfg_wp_n;
  logic cfg_bottom, next_cfg_bottom, next_pslverr, in_boot;
  logic [31:0] next_prdata;
  logic [15:0] dq_s1, dq_s2, dq_s3;
  flash_host_pkg::flash_pins_t next_flash;
  flash_host_pkg::seq_word_t sw, nsw;

  assign pready = penable;

  always_comb begin
    next_state = state;
    next_op = op;
    next_addr = addr;
    next_wdata = wdata;
    next_rdata = rdata;
    next_step = step;
    next_timer = timer + 12'h001;
    next_busy = busy;
    next_done = done;
    next_refused = refused;
    next_reissue = reissue;
    next_suspended = suspended;
    next_polling = polling;
    next_prev_valid = prev_valid;
    next_prev_bit = prev_bit;
    next_cfg_wp_n = cfg_wp_n;
    next_cfg_bottom = cfg_bottom;
    next_prdata = prdata;
    next_pslverr = pslverr;
    go_op = flash_host_pkg::op_t'(pwdata[3:0]);
    sw = seq_word(op, step, addr, wdata);
    in_boot = addr[20:15] == (cfg_bottom ? flash_host_pkg::BOOT_BOTTOM_TAG
                                         : flash_host_pkg::BOOT_TOP_TAG);
    if (psel && !penable) begin
      next_pslverr = 1'b0;
      if (paddr == flash_host_pkg::REG_CTRL) begin
        next_prdata = {28'h0000000, op};
      end else if (paddr == flash_host_pkg::REG_ADDR) begin
        next_prdata = {11'h000, addr};
      end else if (paddr == flash_host_pkg::REG_WDATA) begin
        next_prdata = {16'h0000, wdata};
      end else if (paddr == flash_host_pkg::REG_STATUS) begin
        next_prdata = {27'h0000000, suspended, reissue, refused, done, busy};
      end else if (paddr == flash_host_pkg::REG_RDATA) begin
        next_prdata = {16'h0000, rdata};
      end else if (paddr == flash_host_pkg::REG_CFG) begin
        next_prdata = {30'h00000000, cfg_bottom, cfg_wp_n};
      end else begin
        next_prdata = 32'h00000000;
        next_pslverr = 1'b1;
      end
    end
    if (psel && penable && pwrite) begin
      if (paddr == flash_host_pkg::REG_STATUS) begin
        next_done = done & ~pwdata[flash_host_pkg::ST_DONE];
        next_refused = refused & ~pwdata[flash_host_pkg::ST_REFUSED];
        next_reissue = reissue & ~pwdata[flash_host_pkg::ST_REISSUE];
      end else if (paddr == flash_host_pkg::REG_CFG) begin
        next_cfg_wp_n = pwdata[flash_host_pkg::CFG_WP];
        next_cfg_bottom = pwdata[flash_host_pkg::CFG_BOTTOM];
      end else if (busy) begin
        // No address, data or command write reaches the flash while an operation runs.  // see [R24]
      end else if (paddr == flash_host_pkg::REG_ADDR) begin
        next_addr = pwdata[20:0];
      end else if (paddr == flash_host_pkg::REG_WDATA) begin
        next_wdata = pwdata[15:0];
      end else if (paddr == flash_host_pkg::REG_CTRL &&
                   pwdata[flash_host_pkg::GO_BIT]) begin
        next_op = go_op;
        next_step = 3'h0;
        next_timer = 12'h000;
        // Refuse to alter the guarded block while protect is low.  // see [R11]
        if (!cfg_wp_n && alters_array(go_op) &&
            (in_boot || go_op == flash_host_pkg::OP_CHIP_ERASE)) begin
          next_refused = 1'b1;
        end else begin
          next_busy = 1'b1;
          if (go_op == flash_host_pkg::OP_HW_RESET) begin
            next_state = S_RST_LOW;
          end else if (go_op == flash_host_pkg::OP_READ) begin
            next_polling = 1'b0;
            next_state = S_RD_LOW;
          end else begin
            next_state = S_WR_LOW;
          end
        end
      end
    end
    case (state)
      S_WR_LOW: begin
        // Strobe held low well beyond the glitch filter.  // see [R09]
        if (timer == flash_host_pkg::WE_LOW_CYC - 12'h001) begin
          next_state = S_WR_HIGH;
          next_timer = 12'h000;
        end
      end
      S_WR_HIGH: begin
        if (timer == flash_host_pkg::WE_HIGH_CYC - 12'h001) begin
          next_timer = 12'h000;
          if (!sw.last) begin
            next_step = step + 3'h1;
            next_state = S_WR_LOW;
          end else if (op == flash_host_pkg::OP_SUSPEND) begin
            next_suspended = 1'b1;
            next_state = S_WAIT; // see [R23]
          end else if (polls(op)) begin
            // Polling starts only once the final strobe has risen.
            next_suspended = suspended && op != flash_host_pkg::OP_RESUME;
            next_polling = 1'b1; // see [R02] [R06]
            next_prev_valid = 1'b0;
            next_state = S_RD_GAP;
          end else begin
            next_busy = 1'b0;
            next_done = 1'b1;
            next_state = S_IDLE;
          end
        end
      end
      S_RD_LOW: begin
        if (timer >= flash_host_pkg::READ_CYC - 12'h001) begin
          next_timer = timer;
          if (dq_s2 == dq_s3) begin
            next_rdata = dq_s3;
            next_timer = 12'h000;
            next_prev_bit = dq_s3[flash_host_pkg::TOGGLE_BIT];
            next_prev_valid = 1'b1;
            next_state = S_RD_GAP;
            // Toggle bit compare, never the polling bit.  // see [R01] [R21]
            if (!polling || (prev_valid &&
                prev_bit == dq_s3[flash_host_pkg::TOGGLE_BIT])) begin
              next_busy = 1'b0;
              next_done = 1'b1;
              next_state = S_IDLE;
            end
          end
        end
      end
      S_RD_GAP: begin
        if (timer == flash_host_pkg::GAP_CYC - 12'h001) begin
          next_timer = 12'h000;
          next_state = S_RD_LOW;
        end
      end
      S_RST_LOW: begin
        if (timer == flash_host_pkg::RST_LOW_CYC - 12'h001) begin // see [R12]
          next_timer = 12'h000;
          next_reissue = reissue | suspended; // see [R13]
          next_suspended = 1'b0;
          next_state = S_WAIT;
        end
      end
      S_WAIT: begin
        if (timer == (op == flash_host_pkg::OP_HW_RESET ?
            flash_host_pkg::RECOV_CYC : flash_host_pkg::SUSPEND_CYC)
            - 12'h001) begin // see [R13]
          next_busy = 1'b0;
          next_done = 1'b1;
          next_state = S_IDLE;
        end
      end
      default: next_timer = 12'h000;
    endcase
    nsw = seq_word(next_op, next_step, next_addr, next_wdata);
    // Output gate is never low while a write strobe is low.  // see [R10]
    next_flash.ce_n = !(next_state == S_WR_LOW || next_state == S_RD_LOW);
    next_flash.we_n = next_state != S_WR_LOW;
    next_flash.oe_n = next_state != S_RD_LOW;
    next_flash.rst_n = next_state != S_RST_LOW;
    next_flash.wp_n = next_cfg_wp_n;
    next_flash.dq_oe_n = !(next_state == S_WR_LOW || next_state == S_WR_HIGH);
    next_flash.dq_out = nsw.data;
    // Reads keep the target address on the pins.  // see [R08]
    next_flash.addr = next_flash.dq_oe_n ? next_addr : nsw.addr;
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state <= S_IDLE;
      op <= flash_host_pkg::OP_READ;
      addr <= 21'h000000;
      wdata <= 16'h0000;
      rdata <= 16'h0000;
      step <= 3'h0;
      timer <= 12'h000;
      busy <= 1'b0;
      done <= 1'b0;
      refused <= 1'b0;
      reissue <= 1'b0;
      suspended <= 1'b0;
      polling <= 1'b0;
      prev_valid <= 1'b0;
      prev_bit <= 1'b0;
      cfg_wp_n <= flash_host_pkg::CFG_WP_RESET;
      cfg_bottom <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
      flash <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, rst_n: 1'b1,
                 wp_n: flash_host_pkg::CFG_WP_RESET, dq_oe_n: 1'b1,
                 addr: 21'h000000, dq_out: 16'h0000};
      dq_s1 <= 16'h0000;
      dq_s2 <= 16'h0000;
      dq_s3 <= 16'h0000;
    end else begin
      state <= next_state;
      op <= next_op;
      addr <= next_addr;
      wdata <= next_wdata;
      rdata <= next_rdata;
      step <= next_step;
      timer <= next_timer;
      busy <= next_busy;
      done <= next_done;
      refused <= next_refused;
      reissue <= next_reissue;
      suspended <= next_suspended;
      polling <= next_polling;
      prev_valid <= next_prev_valid;
      prev_bit <= next_prev_bit;
      cfg_wp_n <= next_cfg_wp_n;
      cfg_bottom <= next_cfg_bottom;
      prdata <= next_prdata;
      pslverr <= next_pslverr;
      flash <= next_flash;
      dq_s1 <= flash_dq_in;
      dq_s2 <= dq_s1;
      dq_s3 <= dq_s2;
    end
  end

  // Helper count of cycles the reset pin has been low.
  logic [11:0] rst_low_cnt;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rst_low_cnt <= 12'h000;
    end else begin
      rst_low_cnt <= flash.rst_n ? 12'h000 : rst_low_cnt + 12'h001;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  AST_NO_GATE_DURING_WRITE: assert property ( // see [R10]
    !(!flash.we_n && !flash.oe_n)) else $error("gate low during write");
  AST_WE_PULSE_WIDTH: assert property ( // see [R09]
    $fell(flash.we_n) |-> !flash.we_n [*5] ##1 flash.we_n)
    else $error("write strobe width wrong");
  AST_UPPER_BYTE_DRIVEN: assert property ( // see [R16]
    (!flash.we_n && step != 3'h3) |-> flash.dq_out[15:8] == 8'h00)
    else $error("command upper byte not low");
  AST_RESET_PULSE: assert property ( // see [R12]
    $rose(flash.rst_n) |-> rst_low_cnt >= flash_host_pkg::RST_LOW_CYC)
    else $error("reset pulse too short");
  AST_RESET_RECOVERY: assert property ( // see [R13]
    $rose(flash.rst_n) |-> flash.oe_n [*7]) else $error("read too soon");
  AST_ADDR_STABLE_READ: assert property ( // see [R08]
    (!flash.oe_n && $past(!flash.oe_n)) |-> $stable(flash.addr))
    else $error("address moved during read");
  AST_BOOT_GUARD: assert property ( // see [R11]
    (state == S_WR_LOW && alters_array(op)) |->
    (cfg_wp_n || (!in_boot && op != flash_host_pkg::OP_CHIP_ERASE)))
    else $error("write into guarded block");
  AST_UNLOCK_FIRST: assert property ( // see [R14]
    ($fell(flash.we_n) && step == 3'h0 && alters_array(op)) |->
    flash.addr == flash_host_pkg::A_UNLOCK1 &&
    flash.dq_out == flash_host_pkg::D_UNLOCK1)
    else $error("unlock prefix missing");
  AST_BUSY_IGNORES: assert property ( // see [R24]
    (busy && psel && penable && pwrite) |=> $stable(op) && $stable(addr))
    else $error("command accepted while busy");
  AST_POLL_END: assert property ( // see [R01]
    ($fell(busy) && polling && state == S_IDLE) |->
    $past(prev_bit) == rdata[flash_host_pkg::TOGGLE_BIT])
    else $error("poll ended without stable toggle bit");

  COV_PROGRAM: cover property ($fell(busy) && op == flash_host_pkg::OP_PROG);
  COV_ERASE: cover property ($fell(busy) && op == flash_host_pkg::OP_SECT_ERASE);
  COV_RESET: cover property ($rose(flash.rst_n));
  COV_SUSPEND: cover property ($rose(suspended));
endmodule

// ---- testbench/flash_model.sv ----
// Behavioural model of the parallel flash device on the host's pins.
`timescale 1ns/1ps
module flash_model #(
  parameter logic [15:0] MAKER_CODE = 16'h00a1, // Arbitrary value.
  parameter logic [15:0] PART_CODE = 16'h0b2c, // Arbitrary value.
  parameter logic BOTTOM = 1'b0
) (
  input wire flash_host_pkg::flash_pins_t pins,
  output logic [15:0] dq
);
  logic [15:0] mem [int];
  logic [15:0] rd = 16'h0000;
  logic [15:0] pdata = 16'h0000;
  logic tog = 1'b0;
  logic erasing = 1'b0;
  logic susp = 1'b0;
  logic armed = 1'b0;
  logic [20:0] ea = 21'h000000;
  logic [7:0] cmd = 8'h00;
  realtime t_fall = 0;
  int step = 0;
  int mode = 0;
  int busy = 0;

  function automatic logic prot(input logic [20:0] a);
    return !pins.wp_n && (a[20:15] == (BOTTOM ? 6'h00 : 6'h3f));
  endfunction

  // Only the low byte is decoded as a command; the upper byte matters only in the data word.
  task automatic wr(input logic [20:0] a, input logic [15:0] d);
    logic [7:0] c;
    c = d[7:0];
    if (busy > 0 && !susp) begin
      if (erasing && c == 8'hb0) susp = 1'b1;
      return;
    end
    if (susp && c == 8'h30) begin
      susp = 1'b0;
      return;
    end
    if (step == 0 && c == 8'hf0) mode = 0;
    if (step == 0 && a == 21'h000055 && c == 8'h98) mode = 2;
    case (step)
      0, 3: step = (c == 8'haa && a[10:0] == 11'h555) ? step + 1 : 0;
      1, 4: step = (c == 8'h55 && a[10:0] == 11'h2aa) ? step + 1 : 0;
      2: begin
        cmd = c;
        // Erase and the word-writing commands expect a fourth cycle.
        step = (c == 8'h80) ? 3 :
          (c == 8'ha0 || c == 8'ha5 || c == 8'h85) ? 6 : 0;
        if (c == 8'h90) mode = 1;
        if (c == 8'h98) mode = 2;
        if (c == 8'h88) mode = 3;
        if (c == 8'hf0) mode = 0;
      end
      5: begin
        step = 0;
        if (c != 8'h10 && c != 8'h30 && c != 8'h50) return;
        if (c == 8'h10 ? !pins.wp_n : prot(a)) return;
        foreach (mem[k]) begin
          if (c == 8'h10 || (c == 8'h50 && k[20:11] == a[20:11]) ||
              (c == 8'h30 && k[20:15] == a[20:15])) mem[k] = 16'hffff;
        end
        erasing = 1'b1;
        busy = 6;
        ea = a;
      end
      default: begin
        step = 0;
        pdata = d;
        if (cmd == 8'ha0 && !prot(a)) mem[int'(a)] = d;
        busy = 3;
      end
    endcase
  endtask

  // Strobes shorter than 5 ns or with the output gate low never write.
  always @(negedge pins.we_n) begin
    armed = !pins.ce_n && pins.oe_n;
    t_fall = $realtime;
  end
  always @(posedge pins.we_n) begin
    if (armed && pins.rst_n && $realtime - t_fall >= 5) begin
      wr(pins.addr, pins.dq_out);
    end
    armed = 1'b0;
  end

  always @(negedge pins.rst_n) begin
    busy = 0;
    erasing = 1'b0;
    susp = 1'b0;
    mode = 0;
    step = 0;
  end

  always @(negedge pins.oe_n or negedge pins.ce_n) begin
    if (!pins.oe_n && !pins.ce_n) begin
      if (susp && pins.addr[20:11] == ea[20:11]) begin
        tog = ~tog;
        rd = {10'h003, 3'b000, tog, 2'b00};
      end else if (busy > 0 && !susp) begin
        tog = ~tog;
        busy--;
        rd = {8'h00, !erasing & ~pdata[7], tog, 3'b000, erasing & tog, 2'b00};
        if (busy == 0) erasing = 1'b0;
      end else begin
        case (mode)
          1: rd = pins.addr[0] ? PART_CODE : MAKER_CODE;
          2: rd = {8'h0d, pins.addr[7:0]};
          3: rd = {8'h51, pins.addr[7:0]};
          default: rd = mem.exists(int'(pins.addr)) ? mem[int'(pins.addr)] : 16'hffff;
        endcase
      end
    end
  end

  // A released bus shows the inverse of its last value, never a held copy.
  assign dq = (!pins.ce_n && !pins.oe_n) ? rd : ~rd;
endmodule

// ---- testbench/tb_top.sv ----
// Self-checking bench for the flash host controller and its flash model.
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("[ERR] %0t got %h expected %h", $time, g, e); end end
module tb_top;
  import flash_host_pkg::*;
  localparam logic [15:0] MAKER = 16'h00a1;
  localparam logic [15:0] PART = 16'h0b2c;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  flash_pins_t pins;
  logic [15:0] dq;
  logic [31:0] q;
  logic err;
  int n_fail = 0;
  int n_checks = 0;
  op_t ers [3] = '{OP_SECT_ERASE, OP_BLOCK_ERASE, OP_CHIP_ERASE};
  op_t mop [5] = '{OP_ID_ENTRY, OP_ID_ENTRY, OP_QUERY_ENTRY, OP_QUERY_SHORT,
    OP_SECID_ENTRY};
  logic [20:0] madr [5] = '{21'h0, 21'h1, 21'h10, 21'h11, 21'h8};
  logic [15:0] mexp [5] = '{MAKER, PART, 16'h0d10, 16'h0d11, 16'h5108};

  flash_host DUT (.mclk(mclk), .arst_n(arst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .flash(pins),
    .flash_dq_in(dq));
  flash_model #(.MAKER_CODE(MAKER), .PART_CODE(PART), .BOTTOM(1'b0)) model (
    .pins(pins), .dq(dq));

  initial forever #4 mclk = ~mclk;

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic tmo();
    $display("[ERR] %0t wait bound used up", $time);
    n_fail++;
    final_report();
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge mclk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (i >= 20) tmo();
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic run(input op_t op, input logic [20:0] a, input logic [15:0] d);
    int i;
    apb(1'b1, REG_STATUS, 32'h0000000e);
    apb(1'b1, REG_ADDR, {11'h000, a});
    apb(1'b1, REG_WDATA, {16'h0000, d});
    apb(1'b1, REG_CTRL, {1'b1, 27'h0, op});
    // A stray address write while busy would derail the operation.
    apb(1'b1, REG_ADDR, 32'h0);
    for (i = 0; i < 3000; i++) begin
      apb(1'b0, REG_STATUS, 32'h0);
      if (q[0] === 1'b0) break;
    end
    if (i == 3000) tmo();
  endtask

  task automatic rdw(input logic [20:0] a);
    run(OP_READ, a, 16'h0000);
    apb(1'b0, REG_RDATA, 32'h0);
  endtask

  initial begin
    repeat (4) @(posedge mclk);
    arst_n <= 1'b1;
    apb(1'b0, REG_CFG, 32'h0);
    `CHK(q, 32'h1)
    apb(1'b0, 8'h40, 32'h0);
    `CHK({err, q}, 33'h100000000)
    for (int k = 0; k < 3; k++) begin
      run(OP_PROG, 21'h000100, 16'h1234);
      `CHK(q[2:0], 3'b010)
      rdw(21'h000100);
      `CHK(q, 32'h1234)
      run(ers[k], 21'h000100, 16'h0000);
      `CHK(q[2:0], 3'b010)
      rdw(21'h000100);
      `CHK(q, 32'hffff)
    end
    apb(1'b1, REG_CFG, 32'h0);
    run(OP_PROG, 21'h1f8000, 16'h5555);
    `CHK(q[2:0], 3'b100)
    run(OP_CHIP_ERASE, 21'h000000, 16'h0000);
    `CHK(q[2:0], 3'b100)
    run(OP_PROG, 21'h000200, 16'h00aa);
    `CHK(q[2:0], 3'b010)
    apb(1'b1, REG_CFG, 32'h2);
    run(OP_PROG, 21'h000300, 16'h0000);
    `CHK(q[2:0], 3'b100)
    apb(1'b1, REG_CFG, 32'h1);
    for (int k = 0; k < 5; k++) begin
      run(mop[k], 21'h000000, 16'h0000);
      rdw(madr[k]);
      `CHK(q[15:0], mexp[k])
      run(OP_EXIT, 21'h000000, 16'h0000);
      rdw(21'h000200);
      `CHK(q[15:0], 16'h00aa)
    end
    run(OP_SECID_PROG, 21'h000008, 16'h1234);
    `CHK(q[2:0], 3'b010)
    run(OP_SECID_LOCK, 21'h000000, 16'h0000);
    `CHK(q[2:0], 3'b010)
    run(OP_ID_ENTRY, 21'h000000, 16'h0000);
    run(OP_SUSPEND, 21'h000000, 16'h0000);
    `CHK(q[4:0], 5'b10010)
    run(OP_RESUME, 21'h000000, 16'h0000);
    `CHK(q[4:0], 5'b00010)
    run(OP_SUSPEND, 21'h000000, 16'h0000);
    run(OP_HW_RESET, 21'h000000, 16'h0000);
    `CHK(q[4:0], 5'b01010)
    rdw(21'h000200);
    `CHK(q[15:0], 16'h00aa)
    final_report();
  end
endmodule
